// file: include/otpp_pkg.sv
// Package of constants and carrier types for the one-time memory programmer.
package otpp_pkg;

    // Clock period in nanoseconds.
    localparam int CLK_NS = 20;

    // Program pulse: nominal width, the band limits, and the cycle counts.
    localparam int PW_NOM_NS = 50000;
    localparam int PW_MIN_NS = 47500;
    localparam int PW_MAX_NS = 52500;
    localparam int PW_MIN_CYC = (PW_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int PW_MAX_CYC = PW_MAX_NS / CLK_NS;
    localparam int PW_NOM_CYC = PW_NOM_NS / CLK_NS;

    // Least setup and hold time for supplies, address, data and output enable.
    localparam int SETUP_NS = 2000;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;

    // Longest output delay after output enable falls.
    localparam int OE_NS = 150;
    localparam int OE_CYC = (OE_NS + CLK_NS - 1) / CLK_NS;

    // Two extra cycles cover the input synchroniser on the data pins.
    localparam int SYNC_CYC = 2;
    localparam int READ_CYC = OE_CYC + SYNC_CYC;

    // Timer width and the preset loaded for each wait (one cycle is spent
    // on the reload itself, so presets are one short of the count).
    localparam int TMR_W = 12;
    localparam logic [TMR_W-1:0] TMR_PW = TMR_W'(PW_NOM_CYC - 1);
    localparam logic [TMR_W-1:0] TMR_SETUP = TMR_W'(SETUP_CYC - 1);
    localparam logic [TMR_W-1:0] TMR_READ = TMR_W'(READ_CYC - 1);

    // Further pulses allowed for one word in the verify loop.
    localparam int MAX_RETRY = 10;

    // Width of the upper byte of an identification word, always zero.
    localparam int UPPER_BYTE_W = 8;

    // Operations the user may start.
    typedef enum logic {
        OTPP_OP_PROGRAM,
        OTPP_OP_IDENTIFY
    } otpp_op_e;

    // One word read back from the memory, handed to the user.
    typedef struct packed {
        logic [17:0] addr;
        logic [15:0] data;
        logic mismatch;
    } otpp_word_s;

endpackage

// file: rtl/otpp_programmer.sv
// Programmer that burns, verifies and identifies a 256K x 16 one-time memory.
// Notes on behaviour
// - Program pulse is chip select low, about 50 us.
// - Start at first address with programming supplies raised.
// - First pass: one pulse per address, no reads.
// - Then verify each address against the intended word.
// - On mismatch, up to ten single pulses, each verified.
// - Still wrong after ten: stop, part failed.
// - Verified word moves on to the next address.
// - Normal supplies, read all again, pass only if equal.
// - Identify: select and enable low, high voltage line.
module otpp_programmer #(
    parameter int ADDR_W = 18,
    parameter int DATA_W = 16
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic start_in,
    input wire otpp_pkg::otpp_op_e op_in,
    input wire logic src_valid_in,
    input wire logic [DATA_W-1:0] src_data_in,
    output logic src_ready_out,
    output otpp_pkg::otpp_word_s rd_word_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in,
    output logic busy_out,
    output logic done_out,
    output logic pass_out,
    output logic fail_out,
    output logic [ADDR_W-1:0] mem_addr_out,
    output logic mem_sel_n_out,
    output logic mem_oe_n_out,
    output logic [DATA_W-1:0] mem_data_out,
    output logic mem_data_oe_out,
    input wire logic [DATA_W-1:0] mem_data_in,
    output logic vcc_prog_out,
    output logic vpp_prog_out,
    output logic id_mode_high_voltage_line_out
);

    typedef enum logic [3:0] {
        S_IDLE, S_RAMP, S_GET, S_P_SU, S_P_PW, S_P_DH, S_GAP, S_V_RD,
        S_RECOVER, S_DROP, S_F_GET, S_F_RD, S_ID_RD, S_END
    } otpp_state_e;

    localparam logic [ADDR_W-1:0] LAST_ADDR = {ADDR_W{1'b1}};
    localparam logic [3:0] RETRY_LIM = 4'(otpp_pkg::MAX_RETRY);

    otpp_state_e state_reg;
    logic [otpp_pkg::TMR_W-1:0] tmr_reg;
    logic [3:0] retry_reg;
    logic verify_reg;
    logic [DATA_W-1:0] want_reg;
    logic [DATA_W-1:0] sync1_reg;
    logic [DATA_W-1:0] sync2_reg;
    logic push;
    otpp_pkg::otpp_word_s push_word;
    logic buf_ready_reg;
    logic tail_valid_reg;
    otpp_pkg::otpp_word_s tail_reg;

    // A wait has elapsed once the timer has run down to zero.
    function automatic logic expired(input logic [otpp_pkg::TMR_W-1:0] t);
        return t == '0;
    endfunction

    // Read data comes from the pins asynchronously, so it is synchronised.
    always_ff @(posedge clk_in) begin
        sync1_reg <= mem_data_in;
        sync2_reg <= sync1_reg;
    end

    // A read result is offered only when the output buffer has room; the
    // sequencer simply waits in its read state otherwise.
    always_comb begin
        push = 1'b0;
        push_word.addr = 18'(mem_addr_out);
        push_word.data = 16'(sync2_reg);
        push_word.mismatch = 1'b0;
        if ((state_reg == S_F_RD) && expired(tmr_reg) && buf_ready_reg) begin
            push = 1'b1;
            push_word.mismatch = (sync2_reg != want_reg);
        end
        if ((state_reg == S_ID_RD) && expired(tmr_reg) && buf_ready_reg) begin
            push = 1'b1;
            push_word.data = {{otpp_pkg::UPPER_BYTE_W{1'b0}},
                sync2_reg[otpp_pkg::UPPER_BYTE_W-1:0]};
        end
    end

    // Main sequencer: drives the memory pins, supplies and status.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_reg <= S_IDLE;
            tmr_reg <= '0;
            retry_reg <= '0;
            verify_reg <= 1'b0;
            want_reg <= '0;
            src_ready_out <= 1'b0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            pass_out <= 1'b0;
            fail_out <= 1'b0;
            mem_addr_out <= '0;
            mem_sel_n_out <= 1'b1;
            mem_oe_n_out <= 1'b1;
            mem_data_out <= '0;
            mem_data_oe_out <= 1'b0;
            vcc_prog_out <= 1'b0;
            vpp_prog_out <= 1'b0;
            id_mode_high_voltage_line_out <= 1'b0;
        end else begin
            if (!expired(tmr_reg)) begin
                tmr_reg <= tmr_reg - 1'b1;
            end
            unique case (state_reg)
                S_IDLE, S_END: begin
                    if (start_in) begin
                        busy_out <= 1'b1;
                        done_out <= 1'b0;
                        pass_out <= 1'b0;
                        fail_out <= 1'b0;
                        mem_addr_out <= '0;
                        verify_reg <= 1'b0;
                        if (op_in == otpp_pkg::OTPP_OP_IDENTIFY) begin
                            // Both strobes low, high voltage line raised.
                            id_mode_high_voltage_line_out <= 1'b1;
                            mem_sel_n_out <= 1'b0;
                            mem_oe_n_out <= 1'b0;
                            tmr_reg <= otpp_pkg::TMR_SETUP;
                            state_reg <= S_ID_RD;
                        end else begin
                            vcc_prog_out <= 1'b1;
                            vpp_prog_out <= 1'b1;
                            tmr_reg <= otpp_pkg::TMR_SETUP;
                            state_reg <= S_RAMP;
                        end
                    end
                end
                S_RAMP: begin
                    if (expired(tmr_reg)) begin
                        src_ready_out <= 1'b1;
                        state_reg <= S_GET;
                    end
                end
                S_GET: begin
                    // Take the intended word for this address.
                    if (src_valid_in) begin
                        src_ready_out <= 1'b0;
                        want_reg <= src_data_in;
                        mem_data_out <= src_data_in;
                        retry_reg <= '0;
                        tmr_reg <= otpp_pkg::TMR_SETUP;
                        if (verify_reg) begin
                            state_reg <= S_GAP;
                        end else begin
                            mem_data_oe_out <= 1'b1;
                            state_reg <= S_P_SU;
                        end
                    end
                end
                S_P_SU: begin
                    // Select low with enable high latches the driven data.
                    if (expired(tmr_reg)) begin
                        mem_sel_n_out <= 1'b0;
                        tmr_reg <= otpp_pkg::TMR_PW;
                        state_reg <= S_P_PW;
                    end
                end
                S_P_PW: begin
                    if (expired(tmr_reg)) begin
                        mem_sel_n_out <= 1'b1;
                        tmr_reg <= otpp_pkg::TMR_SETUP;
                        state_reg <= S_P_DH;
                    end
                end
                S_P_DH: begin
                    if (expired(tmr_reg)) begin
                        mem_data_oe_out <= 1'b0;
                        tmr_reg <= otpp_pkg::TMR_SETUP;
                        state_reg <= S_GAP;
                    end
                end
                S_GAP: begin
                    if (expired(tmr_reg)) begin
                        if (verify_reg) begin
                            // Select high, enable low: memory drives data.
                            mem_oe_n_out <= 1'b0;
                            tmr_reg <= otpp_pkg::TMR_READ;
                            state_reg <= S_V_RD;
                        end else if (mem_addr_out == LAST_ADDR) begin
                            // No read in the first pass; verify starts now.
                            mem_addr_out <= '0;
                            verify_reg <= 1'b1;
                            src_ready_out <= 1'b1;
                            state_reg <= S_GET;
                        end else begin
                            mem_addr_out <= mem_addr_out + 1'b1;
                            src_ready_out <= 1'b1;
                            state_reg <= S_GET;
                        end
                    end
                end
                S_V_RD: begin
                    if (expired(tmr_reg)) begin
                        mem_oe_n_out <= 1'b1;
                        tmr_reg <= otpp_pkg::TMR_SETUP;
                        if (sync2_reg == want_reg) begin
                            if (mem_addr_out == LAST_ADDR) begin
                                state_reg <= S_DROP;
                            end else begin
                                mem_addr_out <= mem_addr_out + 1'b1;
                                src_ready_out <= 1'b1;
                                state_reg <= S_GET;
                            end
                        end else if (retry_reg == RETRY_LIM) begin
                            // The part is rejected; supplies come down.
                            fail_out <= 1'b1;
                            vcc_prog_out <= 1'b0;
                            vpp_prog_out <= 1'b0;
                            busy_out <= 1'b0;
                            done_out <= 1'b1;
                            state_reg <= S_END;
                        end else begin
                            retry_reg <= retry_reg + 1'b1;
                            state_reg <= S_RECOVER;
                        end
                    end
                end
                S_RECOVER: begin
                    // Outputs must float before the programmer drives data.
                    if (expired(tmr_reg)) begin
                        mem_data_oe_out <= 1'b1;
                        tmr_reg <= otpp_pkg::TMR_SETUP;
                        state_reg <= S_P_SU;
                    end
                end
                S_DROP: begin
                    // Both supplies return to normal before the final read.
                    vcc_prog_out <= 1'b0;
                    vpp_prog_out <= 1'b0;
                    mem_addr_out <= '0;
                    if (expired(tmr_reg)) begin
                        src_ready_out <= 1'b1;
                        state_reg <= S_F_GET;
                    end
                end
                S_F_GET: begin
                    if (src_valid_in) begin
                        src_ready_out <= 1'b0;
                        want_reg <= src_data_in;
                        mem_sel_n_out <= 1'b0;
                        mem_oe_n_out <= 1'b0;
                        tmr_reg <= otpp_pkg::TMR_READ;
                        state_reg <= S_F_RD;
                    end
                end
                S_F_RD: begin
                    if (push) begin
                        mem_sel_n_out <= 1'b1;
                        mem_oe_n_out <= 1'b1;
                        if (push_word.mismatch) begin
                            fail_out <= 1'b1;
                        end
                        if (mem_addr_out == LAST_ADDR) begin
                            pass_out <= !(fail_out || push_word.mismatch);
                            busy_out <= 1'b0;
                            done_out <= 1'b1;
                            state_reg <= S_END;
                        end else begin
                            mem_addr_out <= mem_addr_out + 1'b1;
                            src_ready_out <= 1'b1;
                            state_reg <= S_F_GET;
                        end
                    end
                end
                S_ID_RD: begin
                    // Lowest address line picks maker then device-type word.
                    if (push) begin
                        tmr_reg <= otpp_pkg::TMR_READ;
                        if (mem_addr_out[0]) begin
                            id_mode_high_voltage_line_out <= 1'b0;
                            mem_sel_n_out <= 1'b1;
                            mem_oe_n_out <= 1'b1;
                            mem_addr_out <= '0;
                            pass_out <= 1'b1;
                            busy_out <= 1'b0;
                            done_out <= 1'b1;
                            state_reg <= S_END;
                        end else begin
                            mem_addr_out[0] <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // Two-entry output buffer; the head drives the port directly, so a
    // stalled reader holds the words and stalls the sequencer behind them.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rd_valid_out <= 1'b0;
            rd_word_out <= '0;
            tail_valid_reg <= 1'b0;
            tail_reg <= '0;
            buf_ready_reg <= 1'b1;
        end else begin
            if (rd_valid_out && rd_ready_in) begin
                if (tail_valid_reg) begin
                    rd_word_out <= tail_reg;
                    tail_valid_reg <= push;
                    tail_reg <= push_word;
                    buf_ready_reg <= !push;
                end else begin
                    rd_valid_out <= push;
                    rd_word_out <= push_word;
                end
            end else if (push) begin
                if (!rd_valid_out) begin
                    rd_valid_out <= 1'b1;
                    rd_word_out <= push_word;
                end else begin
                    tail_valid_reg <= 1'b1;
                    tail_reg <= push_word;
                    buf_ready_reg <= 1'b0;
                end
            end
        end
    end

endmodule

// file: testbench/otpp_props.sv
// Checker of pin timing and result rules for the memory programmer.
module otpp_props #(
    parameter int ADDR_W = 18
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire otpp_pkg::otpp_word_s rd_word_out,
    input wire logic rd_valid_out,
    input wire logic rd_ready_in,
    input wire logic done_out,
    input wire logic pass_out,
    input wire logic fail_out,
    input wire logic [ADDR_W-1:0] mem_addr_out,
    input wire logic mem_sel_n_out,
    input wire logic mem_oe_n_out,
    input wire logic mem_data_oe_out,
    input wire logic vcc_prog_out,
    input wire logic vpp_prog_out,
    input wire logic id_mode_high_voltage_line_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    logic [11:0] low_cnt_reg;
    logic [7:0] pulse_cnt_reg;
    logic [ADDR_W-1:0] last_addr_reg;

    // Pulse length and pulses per address; a new address restarts the
    // count, so only the re-pulses of one visit are bounded.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            low_cnt_reg <= 12'h000;
            pulse_cnt_reg <= 8'h00;
        end else begin
            low_cnt_reg <= (!mem_sel_n_out && mem_oe_n_out) ?
                low_cnt_reg + 12'h001 : 12'h000;
            if (mem_addr_out != last_addr_reg) begin
                pulse_cnt_reg <= 8'h00;
            end else if ($fell(mem_sel_n_out) && mem_oe_n_out) begin
                pulse_cnt_reg <= pulse_cnt_reg + 8'h01;
            end
        end
        last_addr_reg <= mem_addr_out;
    end

    a_pulse_width_band: assert property (
        $rose(mem_sel_n_out) && $past(mem_oe_n_out) && mem_oe_n_out |->
        low_cnt_reg >= otpp_pkg::PW_MIN_CYC &&
        low_cnt_reg <= otpp_pkg::PW_MAX_CYC)
        else $error("program pulse width out of band");
    a_pulse_supplies: assert property (
        !mem_sel_n_out && mem_oe_n_out |->
        vcc_prog_out && vpp_prog_out && mem_data_oe_out)
        else $error("pulse without raised supplies or data");
    a_no_contention: assert property (
        !mem_oe_n_out |-> !mem_data_oe_out)
        else $error("data driven while memory outputs enabled");
    a_retry_bound: assert property (
        pulse_cnt_reg <= 8'h0a)
        else $error("too many pulses on one address");
    a_verify_wait: assert property (
        $fell(mem_oe_n_out) && mem_sel_n_out |-> (!mem_oe_n_out) [*8])
        else $error("verify read shorter than output delay");
    a_read_normal_supply: assert property (
        !mem_sel_n_out && !mem_oe_n_out |-> !vcc_prog_out && !vpp_prog_out)
        else $error("read with programming supplies raised");
    a_id_address: assert property (
        id_mode_high_voltage_line_out && !mem_sel_n_out |->
        !mem_oe_n_out && mem_addr_out[ADDR_W-1:1] == '0)
        else $error("identify with wrong pins");
    a_fail_idle: assert property (
        fail_out && done_out |->
        !vcc_prog_out && !vpp_prog_out && mem_sel_n_out)
        else $error("failed part left powered");
    a_result_exclusive: assert property (
        $rose(done_out) |-> pass_out != fail_out)
        else $error("result not exactly one of pass and fail");
    a_rd_word_hold: assert property (
        rd_valid_out && !rd_ready_in |=> rd_valid_out && $stable(rd_word_out))
        else $error("read word dropped while stalled");

    c_failed: cover property ($rose(fail_out));
    c_repulsed: cover property (pulse_cnt_reg == 8'h03);
    c_identify: cover property (id_mode_high_voltage_line_out);
endmodule

bind otpp_programmer otpp_props #(.ADDR_W(ADDR_W)) u_props (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .rd_word_out(rd_word_out),
    .rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready_in),
    .done_out(done_out), .pass_out(pass_out), .fail_out(fail_out),
    .mem_addr_out(mem_addr_out), .mem_sel_n_out(mem_sel_n_out),
    .mem_oe_n_out(mem_oe_n_out), .mem_data_oe_out(mem_data_oe_out),
    .vcc_prog_out(vcc_prog_out), .vpp_prog_out(vpp_prog_out),
    .id_mode_high_voltage_line_out(id_mode_high_voltage_line_out)
);

// file: testbench/otpp_mem_model.sv
// Behavioural model of the one-time memory at the programmer's pins.
module otpp_mem_model #(
    parameter int AW = 2,
    parameter logic [15:0] MAKER_ID = 16'h005a, // Arbitrary value.
    parameter logic [15:0] DEVICE_ID = 16'h00c3 // Arbitrary value.
) (
    input wire logic clk_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic sel_n_in,
    input wire logic oe_n_in,
    input wire logic [15:0] data_in,
    input wire logic vcc_prog_in,
    input wire logic vpp_prog_in,
    input wire logic hv_in,
    output logic [15:0] data_out
);
    logic [15:0] cells [2**AW];
    logic [15:0] flt = 16'h0f0f;
    int pulses [2**AW];
    int width = 0;
    int bad = 0;
    int weak_addr = -1;
    int weak_need = 0;
    int marg_addr = -1;

    // Blank the cells and clear counts and commanded faults.
    task automatic erase();
        foreach (cells[i]) begin
            cells[i] = 16'hffff;
            pulses[i] = 0;
        end
        bad = 0;
        weak_addr = -1;
        marg_addr = -1;
    endtask

    // A pulse burns its word when select rises; a weak word needs more.
    always @(posedge clk_in) begin
        flt = ~flt; // Released pins show a changing pattern.
        if (!sel_n_in && oe_n_in) begin
            width++;
        end else if (width > 0) begin
            if (width < otpp_pkg::PW_MIN_CYC || width > otpp_pkg::PW_MAX_CYC)
                bad++;
            if (!vcc_prog_in || !vpp_prog_in)
                bad++;
            pulses[addr_in]++;
            if (int'(addr_in) != weak_addr || pulses[addr_in] >= weak_need)
                cells[addr_in] &= data_in;
            width = 0;
        end
    end

    // A marginal word reads wrong only at normal supply.
    always_comb begin
        if (!oe_n_in && !sel_n_in && hv_in) begin
            data_out = {8'h00, addr_in[0] ? DEVICE_ID[7:0] : MAKER_ID[7:0]};
        end else if (!oe_n_in) begin // above, here
            data_out = cells[addr_in] ^
                {15'h0000, int'(addr_in) == marg_addr && !vcc_prog_in};
        end else begin
            data_out = flt;
        end
    end
endmodule

// file: testbench/otpp_programmer_test.sv
// Self-checking testbench of the one-time memory programmer.
module otpp_programmer_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int AW = 2;
    localparam int NW = 4;
    localparam logic [15:0] MAKER_ID = 16'h005a; // Arbitrary value.
    localparam logic [15:0] DEVICE_ID = 16'h00c3; // Arbitrary value.
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic start_in = 1'b0;
    logic src_valid_in = 1'b1;
    logic rd_ready_in = 1'b1;
    otpp_pkg::otpp_op_e op_in = otpp_pkg::OTPP_OP_IDENTIFY;
    logic [15:0] src_data_in, mem_q, mem_bus, mem_data_out;
    logic [AW-1:0] mem_addr_out;
    otpp_pkg::otpp_word_s rd_word_out;
    otpp_pkg::otpp_word_s got_q[$];
    logic src_ready_out, rd_valid_out, busy_out, done_out, pass_out;
    logic fail_out, mem_sel_n_out, mem_oe_n_out, mem_data_oe_out;
    logic vcc_prog_out, vpp_prog_out, id_mode_high_voltage_line_out;
    int n_fail = 0;
    int n_tests = 0;
    int src_idx = 0;
    logic [15:0] img [NW] = '{16'h1234, 16'h00ff, 16'hfe01, 16'h5aa5};

    always #10 clk_in = ~clk_in;
    // Source words repeat in address order for each pass.
    assign src_data_in = img[src_idx % NW];
    // The programmer's drivers take the pins over from the memory.
    assign mem_bus = mem_data_oe_out ? mem_data_out : mem_q;

    // Take source words and collect read words on their handshakes.
    always @(posedge clk_in) begin
        if (rd_valid_out === 1'b1 && rd_ready_in) got_q.push_back(rd_word_out);
        if (src_ready_out === 1'b1) #1 src_idx++;
    end

    otpp_programmer #(.ADDR_W(AW), .DATA_W(16)) u_dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .start_in(start_in),
        .op_in(op_in), .src_valid_in(src_valid_in), .src_data_in(src_data_in),
        .src_ready_out(src_ready_out), .rd_word_out(rd_word_out),
        .rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready_in),
        .busy_out(busy_out), .done_out(done_out), .pass_out(pass_out),
        .fail_out(fail_out), .mem_addr_out(mem_addr_out),
        .mem_sel_n_out(mem_sel_n_out), .mem_oe_n_out(mem_oe_n_out),
        .mem_data_out(mem_data_out), .mem_data_oe_out(mem_data_oe_out),
        .mem_data_in(mem_bus), .vcc_prog_out(vcc_prog_out),
        .vpp_prog_out(vpp_prog_out),
        .id_mode_high_voltage_line_out(id_mode_high_voltage_line_out));
    otpp_mem_model #(.AW(AW), .MAKER_ID(MAKER_ID), .DEVICE_ID(DEVICE_ID))
        u_mem (.clk_in(clk_in), .addr_in(mem_addr_out),
        .sel_n_in(mem_sel_n_out), .oe_n_in(mem_oe_n_out), .data_in(mem_bus),
        .vcc_prog_in(vcc_prog_out), .vpp_prog_in(vpp_prog_out),
        .hv_in(id_mode_high_voltage_line_out), .data_out(mem_q));

    task chk_v(input string w, input logic [33:0] e, input logic [33:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", w, e, g);
        end
    endtask
    task chk_f(input string w, input logic [1:0] e, input logic [1:0] g);
        chk_v(w, {32'h0, e}, {32'h0, g});
    endtask
    task chk_c(input string w, input int e, input int g);
        chk_v(w, 34'(e), 34'(g));
    endtask
    function automatic logic [33:0] gw(input int i);
        return {got_q[i].addr, got_q[i].data};
    endfunction

    // Start one operation and wait, bounded, for its end.
    task run(input otpp_pkg::otpp_op_e op);
        int k;
        got_q.delete();
        src_idx = 0;
        op_in = op;
        start_in = 1'b1;
        @(posedge clk_in);
        #1 start_in = 1'b0;
        chk_f("busy", 2'b01, {1'b0, busy_out});
        for (k = 0; k < 60000 && done_out !== 1'b1; k++) @(posedge clk_in);
        repeat (8) @(posedge clk_in);
        // Leave the next scenario's first drive off the clock edge.
        #1;
    endtask
    // Final-pass words in order, marked as bad where expected.
    task words(input logic [NW-1:0] bad);
        chk_c("word count", NW, got_q.size());
        for (int i = 0; i < NW; i++) begin
            chk_v("word", {18'(i), img[i] ^ {15'h0, bad[i]}}, gw(i));
            chk_f("mismatch", {1'b0, bad[i]}, {1'b0, got_q[i].mismatch});
        end
    endtask

    task t_identify();
        run(otpp_pkg::OTPP_OP_IDENTIFY);
        chk_c("id count", 2, got_q.size());
        chk_v("maker", {18'h0, 8'h00, MAKER_ID[7:0]}, gw(0));
        chk_v("device", {18'h1, 8'h00, DEVICE_ID[7:0]}, gw(1));
    endtask
    // The reader stalls at the first word; nothing may be lost.
    task t_program_ok();
        u_mem.erase();
        fork
            run(otpp_pkg::OTPP_OP_PROGRAM);
            begin
                rd_ready_in = 1'b0;
                wait (rd_valid_out === 1'b1);
                repeat (300) @(posedge clk_in);
                #1 rd_ready_in = 1'b1;
            end
        join
        words(4'b0000);
        for (int i = 0; i < NW; i++) chk_c("pulses", 1, u_mem.pulses[i]);
        chk_c("pulse faults", 0, u_mem.bad);
        chk_f("result", 2'b10, {pass_out, fail_out});
    endtask
    task t_retry();
        u_mem.erase();
        u_mem.weak_addr = 2;
        u_mem.weak_need = 4;
        run(otpp_pkg::OTPP_OP_PROGRAM);
        chk_c("weak pulses", 4, u_mem.pulses[2]);
        chk_c("next pulses", 1, u_mem.pulses[3]);
        words(4'b0000);
        chk_f("result", 2'b10, {pass_out, fail_out});
    endtask
    task t_fail();
        u_mem.erase();
        u_mem.weak_addr = 1;
        u_mem.weak_need = 30;
        run(otpp_pkg::OTPP_OP_PROGRAM);
        chk_c("dead pulses", 11, u_mem.pulses[1]);
        chk_c("later pulses", 1, u_mem.pulses[2]);
        chk_c("final words", 0, got_q.size());
        chk_f("result", 2'b01, {pass_out, fail_out});
        chk_f("supplies", 2'b00, {vcc_prog_out, vpp_prog_out});
    endtask
    task t_final();
        u_mem.erase();
        u_mem.marg_addr = 3;
        run(otpp_pkg::OTPP_OP_PROGRAM);
        words(4'b1000);
        chk_f("result", 2'b01, {pass_out, fail_out});
    endtask

    task tally_and_finish();
        if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Main sequence after a reset of twenty cycles.
    initial begin
        repeat (20) @(posedge clk_in);
        #1 sys_rst_in = 1'b0;
        t_identify();
        t_program_ok();
        t_retry();
        t_fail();
        t_final();
        tally_and_finish();
    end
    // The scenarios need about 86000 cycles; this cuts a hang short.
    initial begin
        repeat (95000) @(posedge clk_in);
        n_fail++;
        tally_and_finish();
    end
endmodule
